/* verilog/adc_ctl_pkg.sv */
`default_nettype none
package adc_ctl_pkg;

	// sample word width per channel
	localparam int SAMPLE_W = 10;

	// register byte offsets on the apb bus
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] SAMPLE_OFS = 8'h08;

	// control register field positions
	localparam int CTRL_RUN_BIT = 0;	// powerdown_ctl, 0 = power down
	localparam int CTRL_FMT_BIT = 1;	// coding_select, 1 = two's complement
	localparam int CTRL_SLP_LSB = 2;	// sleep_channel_sel, two bits
	localparam int CTRL_OE_BIT  = 4;	// 1 = parallel outputs high impedance

	// status and sample register field positions
	localparam int STAT_MODE_LSB  = 0;
	localparam int STAT_FLAG_LSB  = 4;
	localparam int SAMPLE_CH1_LSB = 16;

	// reset: chip powered down, both channels selected, outputs driven
	localparam logic [31:0] CTRL_RESET = 32'h0000000C;

	// sleep selector codes
	localparam logic [1:0] SLP_ALL_SLEEP = 2'h0;

	// restart times and the cycle counts derived from them (least times round up)
	localparam int CLK_PERIOD_NS   = 20;
	localparam int REF_SETTLE_NS   = 10000;
	localparam int WAKE_NS         = 1000;
	localparam int REF_SETTLE_CYC  = (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_CYC        = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W           = 10;

	// codes short of numeric full scale at which the output clips
	localparam int CLIP_MARGIN = 8;

	typedef enum logic [2:0]
	{
		MODE_OFF    = 3'b000,
		MODE_SETTLE = 3'b001,
		MODE_SLEEP  = 3'b010,
		MODE_WAKE   = 3'b011,
		MODE_ACTIVE = 3'b100
	} mode_t;

	// one channel's output bundle
	typedef struct packed
	{
		logic [SAMPLE_W-1:0] word;
		logic                over;
		logic                under;
		logic                valid;
	} chan_out_t;

endpackage : adc_ctl_pkg
`default_nettype wire

/* verilog/chan_coder.sv */
`timescale 1ns/100ps
`default_nettype none
module chan_coder
	import adc_ctl_pkg::*;
#(
	parameter int W = SAMPLE_W
)
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic signed [W+1:0] raw,
	input  wire logic                strobe,
	input  wire logic                en,
	input  wire logic                fmt,
	output chan_out_t                out_ff
);

	localparam logic signed [W+1:0] HI_LIM = (W+2)'(2**(W-1) - 1 - CLIP_MARGIN);
	localparam logic signed [W+1:0] LO_LIM = (W+2)'(-(2**(W-1)) + CLIP_MARGIN);

	initial
	begin
		if (W != SAMPLE_W)
			$error("chan_coder: W must equal SAMPLE_W");
	end

	chan_out_t nxt_out;

	// clip short of full scale: offset correction would lose codes at one end
	always_comb
	begin
		nxt_out       = out_ff;
		nxt_out.valid = 1'b0;
		if (!en)
		begin
			nxt_out = '0;	// sleeping channel never claims a sample [RULE_15]
		end
		else if (strobe)
		begin
			nxt_out.valid = 1'b1;
			nxt_out.over  = raw > HI_LIM;	// [RULE_03]
			nxt_out.under = raw < LO_LIM;	// [RULE_03]
			if (raw > HI_LIM)
				nxt_out.word = '1;	// [RULE_02]
			else if (raw < LO_LIM)
				nxt_out.word = '0;	// [RULE_02]
			else if (fmt)
				nxt_out.word = raw[W-1:0];	// [RULE_04] [RULE_06]
			else
				nxt_out.word = {~raw[W-1], raw[W-2:0]};	// [RULE_04] [RULE_05]
		end
	end

	// rising edge only, the falling edge is never used [RULE_14]
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			out_ff <= '0;
		else
			out_ff <= nxt_out;
	end

	AST_OVER_ONES: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
		strobe && en && raw > HI_LIM |=> out_ff.over && out_ff.word == '1)
		else $error("overrange word not all ones");

	AST_UNDER_ZEROS: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
		strobe && en && raw < LO_LIM |=> out_ff.under && out_ff.word == '0)
		else $error("underrange word not all zeros");

	AST_CLIP_EARLY: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
		strobe && en && raw == HI_LIM + 1 |=> out_ff.over)
		else $error("no clip just above limit");

	AST_TWOS: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
		strobe && en && fmt && raw <= HI_LIM && raw >= LO_LIM
		|=> !out_ff.over && out_ff.word == $past(raw[W-1:0]))
		else $error("two's complement word wrong");

	AST_OFFSET: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
		strobe && en && !fmt && raw <= HI_LIM && raw >= LO_LIM
		|=> out_ff.word == ($past(raw[W-1:0]) ^ (W'(1) << (W-1))))
		else $error("offset binary word wrong");

endmodule : chan_coder
`default_nettype wire

/* verilog/adc_mode_ctrl.sv */
// Behaviour
// RULE_01: output-disable bit set means all parallel data outputs go high impedance.
// RULE_02: out-of-range forces word to all ones (over) or all zeros (under).
// RULE_03: clipping and range flags occur before numeric full-scale code is reached.
// RULE_04: coding_select low gives offset binary, high gives two's complement.
// RULE_05: offset binary: full scale ones, mid code above zero, mid-1 below.
// RULE_06: two's complement: max positive, zero, all ones, most negative word.
// RULE_07: powerdown_ctl low overrides all controls, turns everything and clock off. Code keeps the output-disable bit in force while powered down.
// RULE_08: sleep select 00 sleep, 01 channel 0, 10 channel 1, 11 both.
// RULE_09: sleep stops internal clocking but keeps low-bandwidth bias powered.
// RULE_10: restart from power-down waits longer than restart from sleep.
// RULE_11: controller keeps the input clock running in idle modes.
// RULE_12: after power-up controller holds power-down at least one clock cycle.
// RULE_13: controller may instead hold power-down low throughout power-up.
// RULE_14: all internal timing uses the rising clock edge only.
// RULE_15: each channel has its own word and flags; sleeping channel never valid.
`timescale 1ns/100ps
`default_nettype none
module adc_mode_ctrl
	import adc_ctl_pkg::*;
#(
	parameter int W = SAMPLE_W
)
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic signed [W+1:0] core_code_ch0,
	input  wire logic signed [W+1:0] core_code_ch1,
	input  wire logic                core_strobe,
	output chan_out_t                ch0_out,
	output chan_out_t                ch1_out,
	output logic                     data_oe_n,
	output logic                     core_clk_run,
	output logic                     bias_on,
	output logic [1:0]               chan_power
);

	initial
	begin
		if (W != SAMPLE_W)
			$error("adc_mode_ctrl: W must equal SAMPLE_W");
		if (REF_SETTLE_CYC <= WAKE_CYC)
			$error("adc_mode_ctrl: power-down restart must exceed sleep restart");
		if (REF_SETTLE_CYC > 2 ** CNT_W || WAKE_CYC < 1)
			$error("adc_mode_ctrl: restart counts do not fit the counter");
	end

	logic [31:0]      ctrl_ff;
	logic [31:0]      prdata_ff;
	logic             pready_ff;
	logic             pslverr_ff;
	mode_t            mode_ff;
	mode_t            nxt_mode;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic             oe_n_ff;
	logic             clk_run_ff;
	logic             bias_ff;
	logic [1:0]       power_ff;
	logic [31:0]      rd_val;
	logic             addr_ok;
	logic             wr_take;
	logic             run;
	logic [1:0]       slp_sel;
	logic [1:0]       chan_en;

	assign run     = ctrl_ff[CTRL_RUN_BIT];
	assign slp_sel = ctrl_ff[CTRL_SLP_LSB +: 2];

	// apb decode: answer comes in the first access cycle, no wait states
	assign addr_ok = paddr == CTRL_OFS || paddr == STATUS_OFS || paddr == SAMPLE_OFS;
	assign wr_take = psel && penable && pready_ff && pwrite && !pslverr_ff;

	// read mux, sampled in the setup cycle so prdata comes from a flip-flop
	always_comb
	begin
		rd_val = '0;
		case (paddr)
			CTRL_OFS:
				rd_val = {27'h0000000, ctrl_ff[4:0]};
			STATUS_OFS:
			begin
				rd_val[STAT_MODE_LSB +: 3] = mode_ff;
				rd_val[STAT_FLAG_LSB +: 4] = {ch1_out.under, ch1_out.over,
					ch0_out.under, ch0_out.over};
			end
			SAMPLE_OFS:
			begin
				rd_val[0 +: SAMPLE_W]              = ch0_out.word;
				rd_val[SAMPLE_CH1_LSB +: SAMPLE_W] = ch1_out.word;
			end
			default:
				rd_val = '0;
		endcase
	end

	// bus answer: pready rises in the access cycle that follows setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= '0;
		end
		else
		begin
			pready_ff  <= psel && !penable;
			pslverr_ff <= psel && !penable && !addr_ok;
			if (psel && !penable)
				prdata_ff <= rd_val;
		end
	end

	// control register; only the five defined bits are kept
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_ff <= CTRL_RESET;
		else if (wr_take && paddr == CTRL_OFS)
			ctrl_ff <= {27'h0000000, pwdata[4:0]};
	end

	// mode sequencer; reset leaves the chip powered down until software starts it
	always_comb
	begin
		nxt_mode = mode_ff;
		nxt_cnt  = cnt_ff;
		if (!run)
		begin
			nxt_mode = MODE_OFF;	// [RULE_07]
			nxt_cnt  = '0;
		end
		else
		begin
			case (mode_ff)
				MODE_OFF:
				begin
					nxt_mode = MODE_SETTLE;	// references must settle first [RULE_10]
					nxt_cnt  = CNT_W'(REF_SETTLE_CYC - 1);
				end
				MODE_SETTLE, MODE_WAKE:
				begin
					if (cnt_ff != '0)
						nxt_cnt = cnt_ff - CNT_W'(1);
					else if (slp_sel == SLP_ALL_SLEEP)
						nxt_mode = MODE_SLEEP;	// [RULE_08]
					else
						nxt_mode = MODE_ACTIVE;
				end
				MODE_SLEEP:
				begin
					if (slp_sel != SLP_ALL_SLEEP)
					begin
						nxt_mode = MODE_WAKE;	// bias kept, short restart [RULE_09] [RULE_10]
						nxt_cnt  = CNT_W'(WAKE_CYC - 1);
					end
				end
				MODE_ACTIVE:
				begin
					if (slp_sel == SLP_ALL_SLEEP)
						nxt_mode = MODE_SLEEP;	// [RULE_08]
				end
				default:
					nxt_mode = MODE_OFF;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_ff <= MODE_OFF;
			cnt_ff  <= '0;
		end
		else
		begin
			mode_ff <= nxt_mode;
			cnt_ff  <= nxt_cnt;
		end
	end

	// power and clock controls follow the next mode so they change with it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clk_run_ff <= 1'b0;
			bias_ff    <= 1'b0;
			power_ff   <= 2'b00;
		end
		else
		begin
			clk_run_ff <= nxt_mode == MODE_SETTLE || nxt_mode == MODE_WAKE
				|| nxt_mode == MODE_ACTIVE;	// [RULE_07] [RULE_09]
			bias_ff    <= nxt_mode != MODE_OFF;	// [RULE_09]
			power_ff   <= (nxt_mode == MODE_ACTIVE || nxt_mode == MODE_WAKE) ?
				slp_sel : 2'b00;	// [RULE_08]
		end
	end

	// tristate control: high means hi-z, low means driving
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			oe_n_ff <= 1'b0;
		else
			oe_n_ff <= ctrl_ff[CTRL_OE_BIT];	// [RULE_01]
	end

	// a channel delivers samples only when powered and fully active
	assign chan_en = (mode_ff == MODE_ACTIVE) ? power_ff : 2'b00;	// [RULE_15]

	chan_coder #(.W(W)) u_ch0
	(
		.pclk    (pclk),
		.presetn (presetn),
		.raw     (core_code_ch0),
		.strobe  (core_strobe && clk_run_ff),
		.en      (chan_en[0]),
		.fmt     (ctrl_ff[CTRL_FMT_BIT]),
		.out_ff  (ch0_out)
	);

	chan_coder #(.W(W)) u_ch1
	(
		.pclk    (pclk),
		.presetn (presetn),
		.raw     (core_code_ch1),
		.strobe  (core_strobe && clk_run_ff),
		.en      (chan_en[1]),
		.fmt     (ctrl_ff[CTRL_FMT_BIT]),
		.out_ff  (ch1_out)
	);

	assign prdata       = prdata_ff;
	assign pready       = pready_ff;
	assign pslverr      = pslverr_ff;
	assign data_oe_n    = oe_n_ff;
	assign core_clk_run = clk_run_ff;
	assign bias_on      = bias_ff;
	assign chan_power   = power_ff;

	AST_TRISTATE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
		ctrl_ff[CTRL_OE_BIT] |=> data_oe_n)
		else $error("outputs not released when disabled");

	AST_PD_OVERRIDE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07]
		!run |=> mode_ff == MODE_OFF && !core_clk_run && !bias_on && chan_power == 2'b00)
		else $error("power-down did not override");

	AST_SLEEP_CLK: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_09]
		mode_ff == MODE_SLEEP && run && slp_sel == SLP_ALL_SLEEP |=> !core_clk_run && bias_on)
		else $error("sleep clocking wrong");

	AST_PD_RESTART: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
		mode_ff == MODE_OFF && run |=> mode_ff != MODE_ACTIVE [*8])
		else $error("restart from power-down too quick");

	AST_SEL_POWER: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_08]
		mode_ff == MODE_ACTIVE && run && slp_sel != SLP_ALL_SLEEP
		|=> chan_power == $past(slp_sel))
		else $error("channel power differs from selector");

	AST_SLEEP_INVALID: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_15]
		ch0_out.valid |-> $past(chan_power[0]) && $past(mode_ff) == MODE_ACTIVE)
		else $error("sleeping channel delivered a sample");

endmodule : adc_mode_ctrl
`default_nettype wire

/* verification/capture_model.sv */
`timescale 1ns/100ps
`default_nettype none
// far-side capture logic: latches each valid word while the outputs are driven
module capture_model
	import adc_ctl_pkg::*;
(
	input  wire logic      pclk,
	input  wire logic      presetn,
	input  wire chan_out_t ch0_out,
	input  wire chan_out_t ch1_out,
	input  wire logic      data_oe_n,
	output chan_out_t      cap0_ff,
	output chan_out_t      cap1_ff,
	output int             cnt0_ff,
	output int             cnt1_ff
);
	// a tristated bus carries nothing, so nothing is taken while it floats
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cap0_ff <= '0;
			cap1_ff <= '0;
			cnt0_ff <= 0;
			cnt1_ff <= 0;
		end
		else
		begin
			if (ch0_out.valid && !data_oe_n)
			begin
				cap0_ff <= ch0_out;
				cnt0_ff <= cnt0_ff + 1;
			end
			if (ch1_out.valid && !data_oe_n)
			begin
				cap1_ff <= ch1_out;
				cnt1_ff <= cnt1_ff + 1;
			end
		end
	end
endmodule : capture_model
`default_nettype wire

/* verification/dual_adc_output_mode_control_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module dual_adc_output_mode_control_bench
	import adc_ctl_pkg::*;
;
	logic                     pclk = 0, presetn = 0, psel = 0, penable = 0;
	logic                     pwrite = 0, core_strobe = 0, pready, pslverr, err;
	logic [7:0]               paddr = 8'h00;
	logic [31:0]              pwdata = 32'h00000000, prdata, rd;
	logic signed [SAMPLE_W+1:0] code0 = '0, code1 = '0;
	logic signed [SAMPLE_W+1:0] tv [8] = '{0, -1, 503, -504, 504, -505, 511, -512};
	chan_out_t                ch0_out, ch1_out, cap0, cap1;
	logic                     data_oe_n, core_clk_run, bias_on;
	logic [1:0]               chan_power;
	int                       cnt0, cnt1, bad_count = 0, comparisons = 0, n;

	adc_mode_ctrl adc_mode_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .core_code_ch0(code0),
		.core_code_ch1(code1), .core_strobe(core_strobe), .ch0_out(ch0_out),
		.ch1_out(ch1_out), .data_oe_n(data_oe_n), .core_clk_run(core_clk_run),
		.bias_on(bias_on), .chan_power(chan_power));
	capture_model capture_model_i (.pclk(pclk), .presetn(presetn), .ch0_out(ch0_out),
		.ch1_out(ch1_out), .data_oe_n(data_oe_n), .cap0_ff(cap0), .cap1_ff(cap1),
		.cnt0_ff(cnt0), .cnt1_ff(cnt1));

	// clock never stops, idle modes included
	always #10 pclk = ~pclk;

	// one apb transfer; waits for pready with no assumed latency
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// one conversion on both channels, then let the capture side take it
	task samp(input logic signed [SAMPLE_W+1:0] a, input logic signed [SAMPLE_W+1:0] b);
		@(posedge pclk);
		code0 <= a;
		code1 <= b;
		core_strobe <= 1'b1;
		@(posedge pclk);
		core_strobe <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
	endtask : samp

	// expected {over, under, word}; clipping sits CLIP_MARGIN short of full scale
	function automatic logic [11:0] code_exp(input logic signed [11:0] r, input logic f);
		if (r > (2 ** (SAMPLE_W - 1)) - 1 - CLIP_MARGIN)
			return {2'b10, 10'h3FF};
		if (r < CLIP_MARGIN - (2 ** (SAMPLE_W - 1)))
			return {2'b01, 10'h000};
		return {2'b00, r[9:0] ^ (f ? 10'h000 : 10'h200)};
	endfunction : code_exp

	// counts edges until the channel power reaches the wanted pattern
	task wait_pwr(input logic [1:0] p);
		n = 0;
		while (chan_power !== p)
		begin
			@(posedge pclk);
			n++;
		end
	endtask : wait_pwr

	// polls the mode field; channel power rises already in wake, so the mode is what counts
	// each poll spans three edges, so n is good to within three cycles
	task wait_mode(input logic [2:0] m);
		n = 0;
		do
		begin
			apb(1'b0, STATUS_OFS, 32'h00000000);
			n += 3;
		end
		while (rd[2:0] !== m);
	endtask : wait_mode

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	initial
	begin
		#(20 * 6000);
		bad_count++;
		report_and_stop();
	end

	initial
	begin
		int settle;
		int c0;
		int c1;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;	// powerdown_ctl stays low through reset and after it
		apb(1'b0, CTRL_OFS, 32'h00000000);
		`CHK("ctrl", CTRL_RESET, rd);
		apb(1'b0, STATUS_OFS, 32'h00000000);
		`CHK("mode", MODE_OFF, rd[2:0]);
		apb(1'b0, 8'h0C, 32'hFFFFFFFF);
		`CHK("err", 1'b1, err);
		`CHK("unmapped", 32'h00000000, rd);
		samp(100, 100);
		`CHK("off cnt", 0, cnt0 + cnt1);
		`CHK("off clk", 2'b00, {core_clk_run, bias_on});
		// powered down for well over a cycle before run is requested
		apb(1'b1, CTRL_OFS, 32'h0000000D);
		wait_pwr(2'b11);
		settle = n;
		`CHK("settle", 1'b1, n >= REF_SETTLE_CYC && n <= REF_SETTLE_CYC + 4);
		for (int f = 0; f < 2; f++)
		begin
			apb(1'b1, CTRL_OFS, f ? 32'h0000000F : 32'h0000000D);
			foreach (tv[i])
			begin
				samp(tv[i], -tv[i]);
				`CHK("ch0", code_exp(tv[i], f[0]), {cap0.over, cap0.under, cap0.word});
				`CHK("ch1", code_exp(-tv[i], f[0]), {cap1.over, cap1.under, cap1.word});
			end
		end
		samp(600, -600);
		apb(1'b0, STATUS_OFS, 32'h00000000);
		`CHK("flags", 4'b1001, rd[7:4]);
		apb(1'b0, SAMPLE_OFS, 32'h00000000);
		`CHK("words", 20'h003FF, {rd[25:16], rd[9:0]});
		for (int s = 1; s < 3; s++)
		begin
			apb(1'b1, CTRL_OFS, {28'h0000000, s[1:0], 2'b01});
			wait_pwr(s[1:0]);
			c0 = cnt0;
			c1 = cnt1;
			samp(5, 5);
			`CHK("sel", s[1:0], {1'(cnt1 - c1), 1'(cnt0 - c0)});
		end
		apb(1'b1, CTRL_OFS, 32'h00000001);
		repeat (3) @(posedge pclk);
		apb(1'b0, STATUS_OFS, 32'h00000000);
		`CHK("sleep", {MODE_SLEEP, 2'b01}, {rd[2:0], core_clk_run, bias_on});
		c0 = cnt0 + cnt1;
		samp(5, 5);
		`CHK("sleep cnt", c0, cnt0 + cnt1);
		apb(1'b1, CTRL_OFS, 32'h0000000D);
		wait_mode(MODE_ACTIVE);
		`CHK("wake", 1'b1, n >= WAKE_CYC && n <= WAKE_CYC + 4 && n < settle);
		`CHK("wake pwr", 2'b11, chan_power);
		apb(1'b1, CTRL_OFS, 32'h0000001D);
		repeat (2) @(posedge pclk);
		#1;
		`CHK("oe", 1'b1, data_oe_n);
		apb(1'b1, CTRL_OFS, 32'h0000000C);
		repeat (2) @(posedge pclk);
		#1;
		`CHK("pd", 4'b0000, {core_clk_run, bias_on, chan_power});
		report_and_stop();
	end
endmodule : dual_adc_output_mode_control_bench
`default_nettype wire
